// [test/tcpu_far.sv]
// Gate driver and converter model: fault trip source, trigger counters
`timescale 1ns/1ps
`default_nettype none
module tcpu_far (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        trip,
  input  wire logic [2:0]  adc_trig,
  output logic             fault_in,
  output logic [2:0][15:0] tcnt
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_in <= 1'b0;
      tcnt     <= '0;
    end else begin
      fault_in <= trip;
      for (int i = 0; i < 3; i++) tcnt[i] <= tcnt[i] + 16'(adc_trig[i]);
    end
  end
endmodule : tcpu_far
`default_nettype wire

// [test/tcpu_monitor.sv]
// Port checker for the three-channel PWM unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module tcpu_monitor
  import tcpu_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        fault_in,
  input wire logic        dbg_stall,
  input wire logic [5:0]  pwm_out,
  input wire logic [2:0]  gen_irq,
  input wire logic [2:0]  adc_trig,
  input wire logic        fault_irq
);
  logic [5:0] en, inv, fen;
  logic [3:0] quiet, fhi;
  logic       wr, rd;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && !pwrite;
  // Shadow of the output control registers; quiet counts cycles since a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en    <= 6'h0;
      inv   <= 6'h0;
      fen   <= 6'h0;
      quiet <= 4'h0;
      fhi   <= 4'h0;
    end else begin
      if (wr && paddr == 12'(OFF_ENABLE)) en <= pwdata[5:0];
      if (wr && paddr == 12'(OFF_INVERT)) inv <= pwdata[5:0];
      if (wr && paddr == 12'(OFF_FAULT)) fen <= pwdata[5:0];
      quiet <= wr ? 4'h0 : quiet + 4'(quiet != 4'hf);
      fhi   <= fault_in ? fhi + 4'(fhi != 4'hf) : 4'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_fault_irq_rise: assert property ($rose(fault_in) |-> ##[2:4] fault_irq)
    else $error("fault interrupt missing after fault rise");
  a_fault_irq_once: assert property (fault_irq |=> !fault_irq)
    else $error("fault interrupt longer than one cycle");
  a_fault_irq_cause: assert property (!fault_in [*6] |-> !fault_irq)
    else $error("fault interrupt without fault");
  a_disabled_low: assert property (quiet >= 4'd3 |-> (pwm_out & ~en & ~inv) == 6'h0)
    else $error("disabled output not at idle level");
  a_fault_force: assert property (fhi >= 4'd6 && quiet >= 4'd3
    |-> ((pwm_out ^ inv) & fen & en) == 6'h0)
    else $error("fault did not force output inactive");
  a_wide_read: assert property (rd && paddr[11:8] == 4'h0 && paddr[7:6] != 2'h0
    && paddr[5:4] == 2'h1 |-> prdata[31:16] == 16'h0)
    else $error("counter or match read wider than 16 bits");
  a_cmd_read: assert property (rd && (paddr == 12'(OFF_CTL) || paddr == 12'(OFF_SYNC))
    |-> prdata == 32'h0)
    else $error("command register read not zero");
  a_enable_read: assert property (rd && paddr == 12'(OFF_ENABLE)
    |-> prdata == {26'h0, en})
    else $error("enable readback wrong");
  c_fault: cover property (fault_irq);
  c_err: cover property (psel && penable && pslverr);
  c_events: cover property (|gen_irq ##[1:8] |adc_trig);
endmodule : tcpu_monitor
bind tcpu_top tcpu_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .fault_in(fault_in), .dbg_stall(dbg_stall), .pwm_out(pwm_out),
  .gen_irq(gen_irq), .adc_trig(adc_trig), .fault_irq(fault_irq)
);
`default_nettype wire

// [test/tcpu_top_tb.sv]
// Self-checking testbench for the three-channel PWM unit
`timescale 1ns/1ps
`default_nettype none
module tcpu_top_tb;
  import tcpu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic fault_in, dbg_stall, fault_irq, trip, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [5:0] pwm_out;
  logic [2:0] gen_irq, adc_trig;
  logic [2:0][15:0] tcnt;
  logic [15:0] n0, n1;
  logic [17:0] obs;
  int miscompares, checks_done;
  assign obs = {gen_irq, adc_trig, ~pwm_out, pwm_out};
  tcpu_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fault_in(fault_in), .dbg_stall(dbg_stall), .pwm_out(pwm_out),
    .gen_irq(gen_irq), .adc_trig(adc_trig), .fault_irq(fault_irq)
  );
  tcpu_far u_far (
    .pclk(pclk), .presetn(presetn), .trip(trip), .adc_trig(adc_trig),
    .fault_in(fault_in), .tcnt(tcnt)
  );
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge pclk);
    #1;
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask : rdc
  function automatic logic [11:0] ga(input int g, input logic [5:0] o);
    return 12'(GEN_BASE) + 12'(g) * 12'(GEN_STRIDE) + 12'(o);
  endfunction : ga
  task automatic upto(input int a, input logic v);
    int t;
    t = 0;
    while (obs[a] !== v) begin
      tick();
      t++;
      if (t > 400) begin
        miscompares++;
        stop_test();
      end
    end
  endtask : upto
  // Cycles from a rise of obs[a] to the next high of obs[b]
  task automatic span(input int a, input int b, output int n);
    upto(a, 1'b0);
    upto(a, 1'b1);
    tick();
    n = 1;
    while (obs[b] !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
  endtask : span
  // First span only lets new settings settle
  task automatic gap(input int a, input int b, input int e);
    int n;
    span(a, b, n);
    span(a, b, n);
    chk(32'(n), 32'(e));
  endtask : gap
  task automatic t_regs;
    rdc(12'(OFF_INVERT), 32'h0);
    rdc(12'(OFF_FAULT), 32'h0);
    rdc(12'(OFF_SYNC), 32'h0);
    rdc(12'(OFF_CTL), 32'h0);
    wr(12'(OFF_ENABLE), 32'hffff_ffff);
    rdc(12'(OFF_ENABLE), 32'h3f);
    wr(ga(0, G_LOAD), 32'habcd_1234);
    rdc(ga(0, G_LOAD), 32'h1234);
    wr(12'(OFF_ENABLE), 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk(32'(re), 32'h1);
    $display("regs test done");
  endtask : t_regs
  task automatic t_down;
    wr(ga(1, G_LOAD), 32'h4);
    wr(ga(1, G_INTEN), 32'h100);
    wr(ga(1, G_CTL), 32'h1);
    gap(13, 13, 5);
    wr(ga(1, G_INTEN), 32'h300);
    gap(13, 13, 1);
    wr(ga(1, G_INTEN), 32'h100);
    wr(ga(1, G_LOAD), 32'h6);
    gap(13, 13, 7);
    wr(ga(1, G_CTL), 32'h9);
    wr(ga(1, G_LOAD), 32'h2);
    gap(13, 13, 7);
    wr(12'(OFF_CTL), 32'h2);
    gap(13, 13, 3);
    $display("down test done");
  endtask : t_down
  task automatic t_updn;
    wr(ga(1, G_CTL), 32'h3);
    wr(ga(1, G_LOAD), 32'h4);
    wr(ga(1, G_CMPA), 32'h1);
    wr(ga(1, G_CMPB), 32'h5);
    wr(ga(1, G_INTEN), 32'h804);
    gap(16, 13, 6);
    wr(ga(1, G_INTEN), 32'h100);
    gap(13, 13, 8);
    wr(ga(1, G_INTEN), 32'h3000);
    repeat (4) tick();
    n0 = tcnt[1];
    repeat (40) tick();
    chk(32'(tcnt[1]), 32'(n0));
    $display("up-down test done");
  endtask : t_updn
  task automatic t_sync;
    wr(ga(1, G_CTL), 32'h1);
    wr(ga(1, G_LOAD), 32'h2);
    wr(ga(1, G_INTEN), 32'h100);
    wr(ga(2, G_LOAD), 32'h2);
    wr(ga(2, G_INTEN), 32'h100);
    wr(ga(2, G_CTL), 32'h1);
    wr(12'(OFF_SYNC), 32'h6);
    gap(13, 14, 3);
    $display("sync test done");
  endtask : t_sync
  task automatic t_stall;
    wr(ga(1, G_CTL), 32'h5);
    @(posedge pclk);
    dbg_stall <= 1'b1;
    repeat (20) tick();
    n0 = tcnt[1];
    n1 = tcnt[2];
    repeat (20) tick();
    chk(32'(tcnt[2]), 32'(n1));
    chk(32'(tcnt[1] != n0), 32'h1);
    @(posedge pclk);
    dbg_stall <= 1'b0;
    $display("stall test done");
  endtask : t_stall
  task automatic t_wave;
    wr(ga(0, G_LOAD), 32'h9);
    wr(ga(0, G_CMPA), 32'h4);
    wr(ga(0, G_GENA), 32'h083);
    wr(ga(0, G_GENB), 32'h001);
    wr(12'(OFF_ENABLE), 32'h3);
    wr(ga(0, G_CTL), 32'h1);
    gap(0, 6, 6);
    gap(1, 7, 10);
    wr(ga(0, G_DBRISE), 32'h2);
    wr(ga(0, G_DBFALL), 32'h3);
    wr(ga(0, G_DBCTL), 32'h1);
    gap(0, 6, 4);
    gap(1, 7, 1);
    wr(12'(OFF_INVERT), 32'h1);
    gap(0, 6, 6);
    @(posedge pclk);
    trip <= 1'b1;
    wr(12'(OFF_FAULT), 32'h3);
    repeat (10) tick();
    chk(32'(pwm_out[1:0]), 32'h1);
    @(posedge pclk);
    trip <= 1'b0;
    $display("wave test done");
  endtask : t_wave
  // Both matches at one count: each output must follow only its own match action
  task automatic t_pair;
    wr(ga(2, G_CMPA), 32'h1);
    wr(ga(2, G_CMPB), 32'h1);
    wr(ga(2, G_GENA), 32'hc40);
    wr(ga(2, G_GENB), 32'h4c0);
    wr(12'(OFF_ENABLE), 32'h30);
    gap(4, 10, 3);
    gap(5, 11, 3);
    $display("pair test done");
  endtask : t_pair
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h0;
    pwdata      = 32'h0;
    dbg_stall   = 1'b0;
    trip        = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_down();
    t_updn();
    t_sync();
    t_stall();
    t_wave();
    t_pair();
    stop_test();
  end
endmodule : tcpu_top_tb
`default_nettype wire

// [verilog/tcpu_gen.sv]
// One generator block: counter, comparators, signal generator, dead-band
`timescale 1ns/1ps
`default_nettype none
module tcpu_gen
  import tcpu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stall,
  tcpu_gen_if.gen   g
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          dir;
    logic [CW-1:0] load;
    logic [CW-1:0] cmpa;
    logic [CW-1:0] cmpb;
    logic          dirty;
    logic          armed;
    logic          a;
    logic          b;
    logic [CW-1:0] dbcnt;
    logic          irq;
    logic          trig;
  } tcpu_gen_st_t;

  tcpu_gen_st_t s, next_s;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] evm;
  logic           run;
  logic           updn;

  function automatic logic act(input logic cur, input logic [1:0] code);
    unique case (code)
      ACT_NONE: act = cur;
      ACT_TOG:  act = ~cur;
      ACT_LOW:  act = 1'b0;
      ACT_HIGH: act = 1'b1;
    endcase
  endfunction : act

  function automatic logic [1:0] sel(input logic [ACT_W-1:0] v, input int unsigned e);
    sel = v[2*e +: 2];
  endfunction : sel

  always_comb begin
    updn = g.ctl[CTL_UPDN];
    // Halt at zero under stall unless set to keep running
    run = g.ctl[CTL_EN] & ~(stall & ~g.ctl[CTL_DBGRUN] & (s.cnt == '0));
    ev = '0;
    ev[EV_ZERO] = run & (s.cnt == '0);
    ev[EV_LOAD] = run & (s.cnt == s.load);
    ev[EV_AU] = run & (s.cnt == s.cmpa) & (s.cmpa <= s.load) & s.dir;
    ev[EV_AD] = run & (s.cnt == s.cmpa) & (s.cmpa <= s.load) & ~s.dir;
    ev[EV_BU] = run & (s.cnt == s.cmpb) & (s.cmpb <= s.load) & s.dir;
    ev[EV_BD] = run & (s.cnt == s.cmpb) & (s.cmpb <= s.load) & ~s.dir;
    evm = ev;
    if (ev[EV_ZERO] | ev[EV_LOAD]) begin
      evm[EV_BD:EV_AU] = '0;
    end
    if (!updn) begin
      evm[EV_AU] = 1'b0;
      evm[EV_BU] = 1'b0;
    end
    next_s = s;
    // Deferred parameter update, ahead of the counter so a reload at zero uses the new load
    if (g.upd_req && s.dirty) begin
      next_s.armed = 1'b1;
    end
    if (ev[EV_ZERO] && s.dirty && (!g.ctl[CTL_SYNCUPD] || s.armed)) begin
      next_s.load = g.pend_load;
      next_s.cmpa = g.pend_cmpa;
      next_s.cmpb = g.pend_cmpb;
      next_s.dirty = 1'b0;
      next_s.armed = 1'b0;
    end
    // Counter
    if (g.cnt_rst) begin
      next_s.cnt = '0;
      next_s.dir = updn;
    end else if (run) begin
      if (!updn) begin
        next_s.dir = 1'b0;
        next_s.cnt = (s.cnt == '0) ? next_s.load : s.cnt - 1'b1;
      end else if (s.dir) begin
        if (s.cnt >= s.load) begin
          next_s.dir = 1'b0;
          next_s.cnt = (s.load == '0) ? '0 : s.cnt - 1'b1;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end else if (s.cnt == '0) begin
        next_s.dir = 1'b1;
        next_s.cnt = (next_s.load == '0) ? '0 : 16'h0001;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
    if (g.param_wr) begin
      next_s.dirty = 1'b1;
    end
    // Signal generator
    for (int unsigned e = 0; e < 2; e++) begin
      if (evm[e]) begin
        next_s.a = act(next_s.a, sel(g.gena, e));
        next_s.b = act(next_s.b, sel(g.genb, e));
      end
    end
    if (evm[EV_AU] | evm[EV_AD]) begin
      next_s.a = act(next_s.a, sel(g.gena, evm[EV_AU] ? EV_AU : EV_AD));
    end else if (evm[EV_BU] | evm[EV_BD]) begin
      next_s.a = act(next_s.a, sel(g.gena, evm[EV_BU] ? EV_BU : EV_BD));
    end
    if (evm[EV_BU] | evm[EV_BD]) begin
      next_s.b = act(next_s.b, sel(g.genb, evm[EV_BU] ? EV_BU : EV_BD));
    end else if (evm[EV_AU] | evm[EV_AD]) begin
      next_s.b = act(next_s.b, sel(g.genb, evm[EV_AU] ? EV_AU : EV_AD));
    end
    // Cycles since the first output last changed, saturating
    if (next_s.a != s.a) begin
      next_s.dbcnt = '0;
    end else if (s.dbcnt != '1) begin
      next_s.dbcnt = s.dbcnt + 1'b1;
    end
    next_s.irq  = |(ev & g.inten[NEV-1:0]);
    next_s.trig = |(ev & g.inten[TRG_POS +: NEV]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    g.count = s.cnt;
    g.irq   = s.irq;
    g.trig  = s.trig;
    if (!g.db_en) begin
      g.out_first  = s.a;
      g.out_second = s.b;
    end else begin
      g.out_first  = s.a & (s.dbcnt >= g.db_rise);
      g.out_second = ~s.a & (s.dbcnt >= g.db_fall);
    end
  end
endmodule : tcpu_gen
`default_nettype wire

// [verilog/tcpu_gen_if.sv]
// Connection between the register block and one generator
`timescale 1ns/1ps
`default_nettype none
interface tcpu_gen_if;
  import tcpu_pkg::*;
  logic [CTL_W-1:0]   ctl;
  logic [CW-1:0]      pend_load;
  logic [CW-1:0]      pend_cmpa;
  logic [CW-1:0]      pend_cmpb;
  logic               param_wr;
  logic               upd_req;
  logic               cnt_rst;
  logic [ACT_W-1:0]   gena;
  logic [ACT_W-1:0]   genb;
  logic               db_en;
  logic [CW-1:0]      db_rise;
  logic [CW-1:0]      db_fall;
  logic [INTEN_W-1:0] inten;
  logic [CW-1:0]      count;
  logic               out_first;
  logic               out_second;
  logic               irq;
  logic               trig;
  modport gen (input ctl, pend_load, pend_cmpa, pend_cmpb, param_wr, upd_req,
               cnt_rst, gena, genb, db_en, db_rise, db_fall, inten,
               output count, out_first, out_second, irq, trig);
  modport ctl_side (output ctl, pend_load, pend_cmpa, pend_cmpb, param_wr,
                    upd_req, cnt_rst, gena, genb, db_en, db_rise, db_fall,
                    inten, input count, out_first, out_second, irq, trig);
endinterface : tcpu_gen_if
`default_nettype wire

// [verilog/tcpu_pkg.sv]
// Constants for the three-channel PWM unit
`default_nettype none
package tcpu_pkg;
  localparam int unsigned NGEN = 3;
  localparam int unsigned CW   = 16;
  // Global register byte offsets
  localparam logic [7:0] OFF_CTL    = 8'h00;
  localparam logic [7:0] OFF_SYNC   = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_INVERT = 8'h0c;
  localparam logic [7:0] OFF_FAULT  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // Generator blocks: base plus stride, then local offsets
  localparam logic [7:0] GEN_BASE   = 8'h40;
  localparam logic [7:0] GEN_STRIDE = 8'h40;
  localparam logic [5:0] G_CTL      = 6'h00;
  localparam logic [5:0] G_INTEN    = 6'h04;
  localparam logic [5:0] G_LOAD     = 6'h10;
  localparam logic [5:0] G_COUNT    = 6'h14;
  localparam logic [5:0] G_CMPA     = 6'h18;
  localparam logic [5:0] G_CMPB     = 6'h1c;
  localparam logic [5:0] G_GENA     = 6'h20;
  localparam logic [5:0] G_GENB     = 6'h24;
  localparam logic [5:0] G_DBCTL    = 6'h28;
  localparam logic [5:0] G_DBRISE   = 6'h2c;
  localparam logic [5:0] G_DBFALL   = 6'h30;
  // Generator control fields
  localparam int unsigned CTL_EN    = 0;
  localparam int unsigned CTL_UPDN  = 1;
  localparam int unsigned CTL_DBGRUN = 2;
  localparam int unsigned CTL_SYNCUPD = 3;
  localparam int unsigned CTL_W     = 4;
  // Event bit positions; actions are two bits per event
  localparam int unsigned EV_ZERO = 0;
  localparam int unsigned EV_LOAD = 1;
  localparam int unsigned EV_AU   = 2;
  localparam int unsigned EV_AD   = 3;
  localparam int unsigned EV_BU   = 4;
  localparam int unsigned EV_BD   = 5;
  localparam int unsigned NEV     = 6;
  localparam int unsigned TRG_POS = 8;
  localparam int unsigned INTEN_W = 14;
  localparam int unsigned ACT_W   = 12;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOG  = 2'h1;
  localparam logic [1:0] ACT_LOW  = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
endpackage : tcpu_pkg
`default_nettype wire

// [verilog/tcpu_top.sv]
// Three-channel PWM unit: APB registers, generators and output stage
//
// Functional notes
// - Count-down: load, down to zero, reload
// - Up/down: zero up to load, back down
// - Direction low in count-down, high counting up
// - Zero and load one-cycle pulses
// - Two comparators pulse on count equal match
// - Up/down matches split by direction
// - Match above load never pulses
// - Four events down mode, six up/down
// - Match ignored when zero or load coincides
// - Coincident matches: each output takes only its own action
// - Per event action: none, toggle, low, high
// - Dead-band off passes both outputs through
// - Dead-band on: first output rising delayed
// - Second output inverted, rising after falling delay
// - Selected events raise interrupt and trigger
// - Interrupt and trigger from raw events
// - Global command resets selected counters together
// - Immediate update takes effect at zero
// - Sync update waits for global request, zero
// - Fault forces enabled outputs inactive, interrupts
// - Stall: halt at zero or keep running
// - Enable register gates outputs, optional inversion
// - Counter, load and match are 16 bits
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tcpu_top
  import tcpu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        fault_in,
  input  wire logic        dbg_stall,
  output logic [5:0]       pwm_out,
  output logic [2:0]       gen_irq,
  output logic [2:0]       adc_trig,
  output logic             fault_irq
);
  typedef struct packed {
    logic [5:0]                 enable;
    logic [5:0]                 invert;
    logic [5:0]                 fault_en;
    logic                       flt_s1;
    logic                       flt_s2;
    logic                       flt_d;
    logic                       flt_irq;
    logic [31:0]                rdata;
    logic                       err;
    logic [5:0]                 pwm;
    logic [2:0]                 irq;
    logic [2:0]                 trig;
    logic [NGEN-1:0][CTL_W-1:0] ctl;
    logic [NGEN-1:0][INTEN_W-1:0] inten;
    logic [NGEN-1:0][CW-1:0]    load;
    logic [NGEN-1:0][CW-1:0]    cmpa;
    logic [NGEN-1:0][CW-1:0]    cmpb;
    logic [NGEN-1:0][ACT_W-1:0] gena;
    logic [NGEN-1:0][ACT_W-1:0] genb;
    logic [NGEN-1:0]            db_en;
    logic [NGEN-1:0][CW-1:0]    db_rise;
    logic [NGEN-1:0][CW-1:0]    db_fall;
  } tcpu_st_t;

  tcpu_st_t       s, next_s;
  tcpu_gen_if     gi [NGEN] ();
  logic           setup;
  logic           wr;
  logic [NGEN-1:0] upd_req;
  logic [NGEN-1:0] cnt_rst;
  logic [NGEN-1:0] param_wr;
  logic [5:0]     raw;
  logic [CW-1:0]  count [NGEN];
  logic [NGEN-1:0] girq;
  logic [NGEN-1:0] gtrig;

  // Decode: which generator an address falls in, or NGEN if none
  function automatic int unsigned gen_of(input logic [11:0] a);
    gen_of = NGEN;
    for (int unsigned i = 0; i < NGEN; i++) begin
      if (a[11:6] == 6'((GEN_BASE + GEN_STRIDE * i) >> 6)) begin
        gen_of = i;
      end
    end
  endfunction : gen_of

  function automatic logic is_mapped(input logic [11:0] a);
    logic       ok;
    logic [5:0] o;
    ok = 1'b0;
    o = a[5:0];
    if (gen_of(a) < NGEN) begin
      ok = (o == G_CTL) | (o == G_INTEN) | (o == G_LOAD) | (o == G_COUNT) |
           (o == G_CMPA) | (o == G_CMPB) | (o == G_GENA) | (o == G_GENB) |
           (o == G_DBCTL) | (o == G_DBRISE) | (o == G_DBFALL);
    end else if (a[11:8] == 4'h0) begin
      ok = (a[7:0] == OFF_CTL) | (a[7:0] == OFF_SYNC) | (a[7:0] == OFF_ENABLE) |
           (a[7:0] == OFF_INVERT) | (a[7:0] == OFF_FAULT) | (a[7:0] == OFF_STATUS);
    end
    is_mapped = ok & (a[1:0] == 2'h0);
  endfunction : is_mapped

  for (genvar i = 0; i < NGEN; i++) begin : g_gen
    assign gi[i].ctl       = s.ctl[i];
    assign gi[i].pend_load = s.load[i];
    assign gi[i].pend_cmpa = s.cmpa[i];
    assign gi[i].pend_cmpb = s.cmpb[i];
    assign gi[i].param_wr  = param_wr[i];
    assign gi[i].upd_req   = upd_req[i];
    assign gi[i].cnt_rst   = cnt_rst[i];
    assign gi[i].gena      = s.gena[i];
    assign gi[i].genb      = s.genb[i];
    assign gi[i].db_en     = s.db_en[i];
    assign gi[i].db_rise   = s.db_rise[i];
    assign gi[i].db_fall   = s.db_fall[i];
    assign gi[i].inten     = s.inten[i];
    assign count[i]        = gi[i].count;
    assign raw[2*i]        = gi[i].out_first;
    assign raw[2*i+1]      = gi[i].out_second;
    assign girq[i]         = gi[i].irq;
    assign gtrig[i]        = gi[i].trig;

    tcpu_gen u_gen (
      .pclk    (pclk),
      .presetn (presetn),
      .stall   (dbg_stall),
      .g       (gi[i])
    );
  end

  always_comb begin
    int unsigned gsel;
    logic [5:0]  o;
    gsel = gen_of(paddr);
    o = paddr[5:0];
    setup = psel & ~penable;
    wr = psel & penable & pwrite & is_mapped(paddr);
    upd_req = '0;
    cnt_rst = '0;
    param_wr = '0;
    next_s = s;
    // Fault pin passes two flip-flops before use
    next_s.flt_s1 = fault_in;
    next_s.flt_s2 = s.flt_s1;
    next_s.flt_d = s.flt_s2;
    next_s.flt_irq = s.flt_s2 & ~s.flt_d;
    next_s.irq = girq;
    next_s.trig = gtrig;
    // Read data and error are prepared in the setup cycle
    if (setup) begin
      next_s.err = ~is_mapped(paddr);
      next_s.rdata = RST_VAL;
      if (gsel < NGEN) begin
        unique case (o)
          G_CTL:    next_s.rdata = 32'(s.ctl[gsel]);
          G_INTEN:  next_s.rdata = 32'(s.inten[gsel]);
          G_LOAD:   next_s.rdata = 32'(s.load[gsel]);
          G_COUNT:  next_s.rdata = 32'(count[gsel]);
          G_CMPA:   next_s.rdata = 32'(s.cmpa[gsel]);
          G_CMPB:   next_s.rdata = 32'(s.cmpb[gsel]);
          G_GENA:   next_s.rdata = 32'(s.gena[gsel]);
          G_GENB:   next_s.rdata = 32'(s.genb[gsel]);
          G_DBCTL:  next_s.rdata = 32'(s.db_en[gsel]);
          G_DBRISE: next_s.rdata = 32'(s.db_rise[gsel]);
          G_DBFALL: next_s.rdata = 32'(s.db_fall[gsel]);
          default:  next_s.rdata = RST_VAL;
        endcase
      end else begin
        unique case (paddr[7:0])
          OFF_ENABLE: next_s.rdata = 32'(s.enable);
          OFF_INVERT: next_s.rdata = 32'(s.invert);
          OFF_FAULT:  next_s.rdata = 32'(s.fault_en);
          OFF_STATUS: next_s.rdata = 32'(s.flt_s2);
          default:    next_s.rdata = RST_VAL;
        endcase
      end
    end
    if (wr) begin
      if (gsel < NGEN) begin
        unique case (o)
          G_CTL:    next_s.ctl[gsel] = pwdata[CTL_W-1:0];
          G_INTEN:  next_s.inten[gsel] = pwdata[INTEN_W-1:0];
          G_LOAD: begin
            next_s.load[gsel] = pwdata[CW-1:0];
            param_wr[gsel] = 1'b1;
          end
          G_CMPA: begin
            next_s.cmpa[gsel] = pwdata[CW-1:0];
            param_wr[gsel] = 1'b1;
          end
          G_CMPB: begin
            next_s.cmpb[gsel] = pwdata[CW-1:0];
            param_wr[gsel] = 1'b1;
          end
          G_GENA:   next_s.gena[gsel] = pwdata[ACT_W-1:0];
          G_GENB:   next_s.genb[gsel] = pwdata[ACT_W-1:0];
          G_DBCTL:  next_s.db_en[gsel] = pwdata[0];
          G_DBRISE: next_s.db_rise[gsel] = pwdata[CW-1:0];
          G_DBFALL: next_s.db_fall[gsel] = pwdata[CW-1:0];
          default:  next_s.err = s.err;
        endcase
      end else begin
        unique case (paddr[7:0])
          OFF_CTL:    upd_req = pwdata[NGEN-1:0];
          OFF_SYNC:   cnt_rst = pwdata[NGEN-1:0];
          OFF_ENABLE: next_s.enable = pwdata[5:0];
          OFF_INVERT: next_s.invert = pwdata[5:0];
          OFF_FAULT:  next_s.fault_en = pwdata[5:0];
          default:    next_s.err = s.err;
        endcase
      end
    end
    // Output stage: gate, force inactive on fault, then polarity
    for (int unsigned k = 0; k < 6; k++) begin
      next_s.pwm[k] = raw[k] & s.enable[k];
      if (s.fault_en[k] && s.flt_s2) begin
        next_s.pwm[k] = 1'b0;
      end
      next_s.pwm[k] = next_s.pwm[k] ^ s.invert[k];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pready    = 1'b1;
  assign prdata    = s.rdata;
  assign pslverr   = psel & penable & s.err;
  assign pwm_out   = s.pwm;
  assign gen_irq   = s.irq;
  assign adc_trig  = s.trig;
  assign fault_irq = s.flt_irq;
endmodule : tcpu_top
`default_nettype wire
